// ### rtl/dpcr_defines.svh
`ifndef DPCR_DEFINES_SVH
`define DPCR_DEFINES_SVH

// Avalon-MM geometry
`define DPCR_ADDR_W 8
`define DPCR_DATA_W 32

// Register byte addresses
`define DPCR_OFS_PLL_CTL 8'h00
`define DPCR_OFS_MUX0 8'h04
`define DPCR_OFS_MUX1 8'h08
`define DPCR_OFS_TRANS_SEL 8'h0c
`define DPCR_OFS_PLL_RATE 8'h10
`define DPCR_OFS_STATUS 8'h14

// Link PLL control fields
`define DPCR_PLL_EN_LSB 0
`define DPCR_GENLOCK_SEL_BIT 4
`define DPCR_PLL_ON_LSB 8
`define DPCR_PLL_LOCK_LSB 12
`define DPCR_GENLOCK_ON_BIT 16

// Port clock mux fields (same layout in both muxes)
`define DPCR_MUX_SRC_LO_BIT 0
`define DPCR_MUX_SRC_HI_BIT 1
`define DPCR_MUX_ON_LO_BIT 2
`define DPCR_MUX_ON_HI_BIT 3

// Per-transcoder select: 4-bit nibble, [1:0] port, [2] enable
`define DPCR_TSEL_STRIDE 4
`define DPCR_TSEL_EN_BIT 2

// Per-PLL rate nibble: [2:0] rate code, [3] spread spectrum
`define DPCR_RATE_STRIDE 4
`define DPCR_RATE_SSC_BIT 3

// Status fields
`define DPCR_ST_GATE_LSB 0
`define DPCR_ST_TRANS_LSB 4

// Reset values
`define DPCR_RST_NIBBLE 4'h0
`define DPCR_RST_WORD16 16'h0000
`define DPCR_RST_DATA 32'h0000_0000

// Clock figures
`define DPCR_REF_KHZ 38400
`define DPCR_SYM_DIV 5
`define DPCR_DIV_LAST 3'h4
`define DPCR_DIV_ZERO 3'h0
`define DPCR_DIV_ONE 3'h1

`endif

// ### rtl/dpcr_div5.sv
`timescale 1ns/100ps
`include "dpcr_defines.svh"

module dpcr_div5
  import dpcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic tick_i,
  output logic tick_o
);

  logic [2:0] cnt_q;
  logic tick_q;

  // Restart on disable so a fresh enable gives full symbol periods
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= `DPCR_DIV_ZERO;
    end else if (!en_i) begin
      cnt_q <= `DPCR_DIV_ZERO;
    end else if (tick_i) begin
      if (cnt_q == `DPCR_DIV_LAST) begin
        cnt_q <= `DPCR_DIV_ZERO;
      end else begin
        cnt_q <= cnt_q + `DPCR_DIV_ONE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= en_i && tick_i && (cnt_q == `DPCR_DIV_LAST);
    end
  end

  assign tick_o = tick_q;

  property p_div_fire;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (en_i && tick_i && cnt_q == `DPCR_DIV_LAST) |=> tick_o;
  endproperty
  a_div_fire: assert property (p_div_fire)
    else $error("divider missed its fifth tick");

  property p_div_only_fifth;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    tick_o |-> $past(cnt_q) == `DPCR_DIV_LAST && $past(en_i);
  endproperty
  a_div_only_fifth: assert property (p_div_only_fifth)
    else $error("divider fired off the fifth tick");

endmodule

// ### rtl/dpcr_pkg.sv
package dpcr_pkg;

  typedef logic [1:0] dpcr_pll_idx_t;
  typedef logic [1:0] dpcr_port_idx_t;

  // Link rate codes held per link PLL
  typedef enum logic [2:0] {
    DPCR_RATE_1G62,
    DPCR_RATE_2G16,
    DPCR_RATE_2G7,
    DPCR_RATE_3G24,
    DPCR_RATE_4G32,
    DPCR_RATE_5G4,
    DPCR_RATE_HDMI,
    DPCR_RATE_HIGH
  } dpcr_rate_t;

endpackage

// ### rtl/dpcr_top.sv
`timescale 1ns/100ps
`include "dpcr_defines.svh"


module dpcr_top
  import dpcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic power_state_low_i,
  input wire logic [3:0] pll_lock_i,
  input wire logic [3:0] link_pll_tick_i,
  output logic ref_clk_on_o,
  output logic [3:0] link_pll_enable_ctl_o,
  output logic [11:0] link_pll_rate_o,
  output logic [3:0] link_pll_ssc_o,
  output logic genlock_filter_pll_en_o,
  output logic genlock_ref_sel_o,
  output logic [3:0] port_clock_gate_o,
  output logic [3:0] port_sym_tick_o,
  output logic [7:0] port_bit_edges_o,
  output logic [3:0] transcoder_tick_o
);

  // Byte-lane merge of a write into a register's old value
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Source PLL of a port: ports A,B use PLLs 0,1; ports C,D use PLLs 2,3
  function automatic dpcr_pll_idx_t port_src(input logic hi_mux,
                                             input logic src_bit);
    return {hi_mux, src_bit};
  endfunction

  logic [3:0] pll_en_q;
  logic genlock_sel_q;
  logic [3:0] mux0_q;
  logic [3:0] mux1_q;
  logic [15:0] trans_sel_q;
  logic [15:0] rate_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic ref_on_q;
  logic [3:0] pll_out_q;
  logic [11:0] rate_out_q;
  logic [3:0] ssc_out_q;
  logic genlock_en_q;
  logic genlock_ref_q;
  logic [3:0] gate_q;
  logic [3:0] sym_q;
  logic [7:0] edges_q;
  logic [3:0] trans_run;
  logic [3:0] trans_tick;

  logic req;
  logic acc;
  logic [3:0] pll_run;
  dpcr_pll_idx_t src [4];
  logic [3:0] port_on;
  logic [3:0] gate_d;
  logic [31:0] status_word;

  // Bus handshake: one wait cycle, then the request completes
  assign req = avs_read_i || avs_write_i;
  assign acc = req && !wait_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Control registers, written on the accepting edge only
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pll_en_q <= `DPCR_RST_NIBBLE;
      genlock_sel_q <= 1'b0;
    end else if (acc && avs_write_i &&
                 avs_address_i == `DPCR_OFS_PLL_CTL) begin
      {genlock_sel_q, pll_en_q} <= 5'(be_merge({27'h0, genlock_sel_q,
                                               pll_en_q}, avs_writedata_i,
                                               avs_byteenable_i));
    end
  end

  // Mapping and enable share one word; software splits them over two
  // writes, so this logic takes each write as it comes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mux0_q <= `DPCR_RST_NIBBLE;
      mux1_q <= `DPCR_RST_NIBBLE;
    end else if (acc && avs_write_i) begin
      if (avs_address_i == `DPCR_OFS_MUX0) begin
        mux0_q <= 4'(be_merge({28'h0, mux0_q}, avs_writedata_i,
                              avs_byteenable_i));
      end else if (avs_address_i == `DPCR_OFS_MUX1) begin
        mux1_q <= 4'(be_merge({28'h0, mux1_q}, avs_writedata_i,
                              avs_byteenable_i));
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trans_sel_q <= `DPCR_RST_WORD16;
      rate_q <= `DPCR_RST_WORD16;
    end else if (acc && avs_write_i) begin
      if (avs_address_i == `DPCR_OFS_TRANS_SEL) begin
        trans_sel_q <= 16'(be_merge({16'h0, trans_sel_q}, avs_writedata_i,
                                    avs_byteenable_i));
      end else if (avs_address_i == `DPCR_OFS_PLL_RATE) begin
        rate_q <= 16'(be_merge({16'h0, rate_q}, avs_writedata_i,
                               avs_byteenable_i));
      end
    end
  end

  // Read data is loaded on the wait cycle so it stands at the accept edge
  always_comb begin
    status_word = `DPCR_RST_DATA;
    status_word[`DPCR_ST_GATE_LSB +: 4] = gate_q;
    status_word[`DPCR_ST_TRANS_LSB +: 4] = trans_run;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `DPCR_RST_DATA;
    end else if (avs_read_i && wait_q) begin
      if (avs_address_i == `DPCR_OFS_PLL_CTL) begin
        rdata_q <= {15'h0, genlock_en_q, pll_lock_i, pll_out_q,
                    3'h0, genlock_sel_q, pll_en_q};
      end else if (avs_address_i == `DPCR_OFS_MUX0) begin
        rdata_q <= {28'h0, mux0_q};
      end else if (avs_address_i == `DPCR_OFS_MUX1) begin
        rdata_q <= {28'h0, mux1_q};
      end else if (avs_address_i == `DPCR_OFS_TRANS_SEL) begin
        rdata_q <= {16'h0, trans_sel_q};
      end else if (avs_address_i == `DPCR_OFS_PLL_RATE) begin
        rdata_q <= {16'h0, rate_q};
      end else if (avs_address_i == `DPCR_OFS_STATUS) begin
        rdata_q <= status_word;
      end else begin
        rdata_q <= `DPCR_RST_DATA;
      end
    end
  end

  // Reference runs from reset on; nothing can turn it off
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_on_q <= 1'b1;
    end else begin
      ref_on_q <= 1'b1;
    end
  end

  // Low power states drop the PLLs; the stored enables bring them back
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pll_out_q <= `DPCR_RST_NIBBLE;
    end else begin
      pll_out_q <= power_state_low_i ? `DPCR_RST_NIBBLE : pll_en_q;
    end
  end

  // Genlock filter PLL follows the filtered-reference select
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      genlock_en_q <= 1'b0;
      genlock_ref_q <= 1'b0;
    end else begin
      genlock_en_q <= genlock_sel_q;
      genlock_ref_q <= genlock_sel_q;
    end
  end

  // Rate setting per PLL; HDMI symbol rates never carry spread
  generate
    for (genvar p = 0; p < 4; p++) begin : g_rate
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          rate_out_q[p*3 +: 3] <= 3'h0;
          ssc_out_q[p] <= 1'b0;
        end else begin
          rate_out_q[p*3 +: 3] <= rate_q[p*`DPCR_RATE_STRIDE +: 3];
          ssc_out_q[p] <= rate_q[p*`DPCR_RATE_STRIDE + `DPCR_RATE_SSC_BIT]
            && (rate_q[p*`DPCR_RATE_STRIDE +: 3] != DPCR_RATE_HDMI);
        end
      end
    end
  endgenerate

  // Port clocks: a port runs only off a powered, locked PLL
  assign pll_run = pll_out_q & pll_lock_i;
  assign src[0] = port_src(1'b0, mux0_q[`DPCR_MUX_SRC_LO_BIT]);
  assign src[1] = port_src(1'b0, mux0_q[`DPCR_MUX_SRC_HI_BIT]);
  assign src[2] = port_src(1'b1, mux1_q[`DPCR_MUX_SRC_LO_BIT]);
  assign src[3] = port_src(1'b1, mux1_q[`DPCR_MUX_SRC_HI_BIT]);
  assign port_on = {mux1_q[`DPCR_MUX_ON_HI_BIT], mux1_q[`DPCR_MUX_ON_LO_BIT],
                    mux0_q[`DPCR_MUX_ON_HI_BIT], mux0_q[`DPCR_MUX_ON_LO_BIT]};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_port
      assign gate_d[i] = port_on[i] && pll_run[src[i]];

      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          gate_q[i] <= 1'b0;
          sym_q[i] <= 1'b0;
          edges_q[i*2 +: 2] <= 2'b00;
        end else begin
          gate_q[i] <= gate_d[i];
          // Port tick is the PLL edge itself; 5 of them make one symbol
          sym_q[i] <= gate_d[i] && link_pll_tick_i[src[i]];
          // Rising and falling edge both clock the I/O
          edges_q[i*2 +: 2] <= {2{gate_d[i] && link_pll_tick_i[src[i]]}};
        end
      end
    end
  endgenerate

  // Transcoders: any number may select the same port clock
  generate
    for (genvar t = 0; t < 4; t++) begin : g_trans
      dpcr_port_idx_t tsel;
      assign tsel = trans_sel_q[t*`DPCR_TSEL_STRIDE +: 2];
      assign trans_run[t] =
        trans_sel_q[t*`DPCR_TSEL_STRIDE + `DPCR_TSEL_EN_BIT] &&
        gate_q[tsel];

      dpcr_div5 u_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(trans_run[t]),
        .tick_i(sym_q[tsel]),
        .tick_o(trans_tick[t])
      );
    end
  endgenerate

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign ref_clk_on_o = ref_on_q;
  assign link_pll_enable_ctl_o = pll_out_q;
  assign link_pll_rate_o = rate_out_q;
  assign link_pll_ssc_o = ssc_out_q;
  assign genlock_filter_pll_en_o = genlock_en_q;
  assign genlock_ref_sel_o = genlock_ref_q;
  assign port_clock_gate_o = gate_q;
  assign port_sym_tick_o = sym_q;
  assign port_bit_edges_o = edges_q;
  assign transcoder_tick_o = trans_tick;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ref_on;
    ref_clk_on_o;
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference clock found off");

  property p_low_power_off;
    power_state_low_i |=> link_pll_enable_ctl_o == 4'h0;
  endproperty
  a_low_power_off: assert property (p_low_power_off)
    else $error("PLL left on in low power state");

  property p_low_power_back;
    !power_state_low_i |=> link_pll_enable_ctl_o == $past(pll_en_q);
  endproperty
  a_low_power_back: assert property (p_low_power_back)
    else $error("PLL enable not restored");

  property p_genlock;
    genlock_sel_q |=> genlock_filter_pll_en_o;
  endproperty
  a_genlock: assert property (p_genlock)
    else $error("genlock filter PLL off while selected");

  property p_hdmi_no_ssc;
    link_pll_rate_o[2:0] == DPCR_RATE_HDMI |-> !link_pll_ssc_o[0];
  endproperty
  a_hdmi_no_ssc: assert property (p_hdmi_no_ssc)
    else $error("spread on HDMI rate");

  property p_gate_needs_pll;
    port_clock_gate_o[0] |-> $past(pll_run[mux0_q[0]]);
  endproperty
  a_gate_needs_pll: assert property (p_gate_needs_pll)
    else $error("port A clock open without running PLL");

  property p_port_d_tick;
    port_sym_tick_o[3] |-> $past(link_pll_tick_i[{1'b1, mux1_q[1]}])
      && port_clock_gate_o[3];
  endproperty
  a_port_d_tick: assert property (p_port_d_tick)
    else $error("port D tick not from its PLL");

  property p_both_edges;
    port_bit_edges_o[1:0] == {2{port_sym_tick_o[0]}};
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("bit edges differ from PLL tick");

  property p_trans_gated;
    transcoder_tick_o[0] |-> $past(trans_run[0], 2) || $past(trans_run[0]);
  endproperty
  a_trans_gated: assert property (p_trans_gated)
    else $error("transcoder tick with clock off");

  property p_bus_wait;
    (req && wait_q) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not one wait cycle");

  property p_reset_off;
    $rose(rst_n_i) |-> port_clock_gate_o == 4'h0 &&
      link_pll_enable_ctl_o == 4'h0 && transcoder_tick_o == 4'h0;
  endproperty
  a_reset_off: assert property (
    @(posedge core_clk_i) p_reset_off)
    else $error("clock on right after reset");

endmodule

// ### verif/dpcr_pll_model.sv
`timescale 1ns/100ps
module dpcr_pll_model #(
  parameter int LOCK_DLY = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] en_i,
  output logic [3:0] lock_o,
  output logic [3:0] tick_o
);
  logic [7:0] dly_q [4];
  logic [2:0] ph_q [4];
  // Lock only after a settle time; a dropped enable loses lock at once
  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (!rst_n_i || !en_i[p]) begin
        dly_q[p] <= 8'h00;
        lock_o[p] <= 1'b0;
      end else if (dly_q[p] < 8'(LOCK_DLY)) begin
        dly_q[p] <= dly_q[p] + 8'h01;
      end else begin
        lock_o[p] <= 1'b1;
      end
    end
  end
  // PLL p gives an edge every p+2 cycles, silent while unlocked
  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (!lock_o[p] || ph_q[p] == 3'(p + 1)) begin
        ph_q[p] <= 3'h0;
      end else begin
        ph_q[p] <= ph_q[p] + 3'h1;
      end
      tick_o[p] <= lock_o[p] && ph_q[p] == 3'(p + 1);
    end
  end
endmodule

// ### verif/tb_display_port_clock_routing.sv
`timescale 1ns/100ps
`include "dpcr_defines.svh"
module tb_display_port_clock_routing;
  import dpcr_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic power_state_low_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, ref_clk_on_o;
  logic genlock_filter_pll_en_o, genlock_ref_sel_o;
  logic [3:0] pll_lock_i, link_pll_tick_i, link_pll_enable_ctl_o;
  logic [3:0] link_pll_ssc_o, port_clock_gate_o, port_sym_tick_o;
  logic [3:0] transcoder_tick_o;
  logic [11:0] link_pll_rate_o;
  logic [7:0] port_bit_edges_o;
  logic [31:0] exp_q [$];
  logic [31:0] r;
  logic [11:0] er;
  logic [3:0] es;
  logic [2:0] code;
  int num_errors = 0;
  int samples_checked = 0;
  int nt [8];

  always #10 core_clk_i = ~core_clk_i;

  dpcr_top i_dut (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .power_state_low_i, .pll_lock_i, .link_pll_tick_i,
    .ref_clk_on_o, .link_pll_enable_ctl_o, .link_pll_rate_o, .link_pll_ssc_o,
    .genlock_filter_pll_en_o, .genlock_ref_sel_o, .port_clock_gate_o,
    .port_sym_tick_o, .port_bit_edges_o, .transcoder_tick_o);

  dpcr_pll_model #(.LOCK_DLY(6)) i_pll (.core_clk_i, .rst_n_i,
    .en_i(link_pll_enable_ctl_o), .lock_o(pll_lock_i),
    .tick_o(link_pll_tick_i));

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hf);
    xfer(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  function automatic logic near(input int a, input int b);
    return a >= b - 1 && a <= b + 1;
  endfunction

  // Settled values are sampled at the falling edge
  task automatic count(input int n);
    nt = '{default: 0};
    repeat (n) begin
      @(negedge core_clk_i);
      nt[0] += link_pll_tick_i[0];
      nt[1] += port_sym_tick_o[0];
      nt[2] += transcoder_tick_o[0];
      nt[3] += transcoder_tick_o[1];
      nt[4] += port_bit_edges_o[1:0] !== {2{port_sym_tick_o[0]}};
      nt[5] += link_pll_tick_i[2];
      nt[6] += port_sym_tick_o[3];
      nt[7] += transcoder_tick_o[2];
    end
  endtask

  always @(posedge core_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      check("readdata", avs_readdata_o, exp_q.pop_front());
  end

  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(82413));
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    wait_cy(2);
    check("ref_clk_on", ref_clk_on_o, 1);
    check("pll_en", link_pll_enable_ctl_o, 0);
    check("gates", port_clock_gate_o, 0);
    check("tr_ticks", transcoder_tick_o, 0);
    check("genlock_pll", genlock_filter_pll_en_o, 0);
    for (int a = 0; a < 7; a++) rd(8'(a * 4), 32'h0);
    wr(8'h18, $urandom());
    rd(8'h18, 32'h0);
    $display("test reset done");
    // Only codes below the high rate: a low-voltage part
    for (int c = 0; c < 7; c++) begin
      r = $urandom() & 32'h0000_ffff;
      for (int p = 0; p < 4; p++) begin
        code = (p == 0) ? 3'(c) : 3'($urandom_range(6, 0));
        r[4*p +: 3] = code;
        er[3*p +: 3] = code;
        es[p] = r[4*p+3] && code != 3'h6;
      end
      wr(`DPCR_OFS_PLL_RATE, r);
      wait_cy(2);
      check("rate", link_pll_rate_o, er);
      check("ssc", link_pll_ssc_o, es);
      rd(`DPCR_OFS_PLL_RATE, r);
    end
    wr(`DPCR_OFS_PLL_RATE, ~r, 4'h2);
    rd(`DPCR_OFS_PLL_RATE, (r & 32'h0000_00ff) | (~r & 32'h0000_ff00));
    $display("test rates done");
    wr(`DPCR_OFS_PLL_CTL, 32'h5);
    wait_cy(12);
    rd(`DPCR_OFS_PLL_CTL, 32'h0000_5505);
    // Mapping and enable go in separate writes, one PLL per port
    wr(`DPCR_OFS_MUX0, 32'h2);
    wr(`DPCR_OFS_MUX0, 32'he);
    wr(`DPCR_OFS_MUX1, 32'h0);
    wr(`DPCR_OFS_MUX1, 32'h8);
    wait_cy(4);
    check("gates", port_clock_gate_o, 4'b1001);
    $display("test port clocks done");
    wr(`DPCR_OFS_TRANS_SEL, 32'h0000_0744);
    wait_cy(12);
    rd(`DPCR_OFS_STATUS, 32'h79);
    count(200);
    check("port_a_ticks", near(nt[1], nt[0]), 1);
    check("port_d_ticks", near(nt[6], nt[5]), 1);
    check("bit_edges", nt[4], 0);
    check("tr0_rate", near(nt[2], nt[0] / 5), 1);
    check("tr1_rate", near(nt[3], nt[0] / 5), 1);
    check("tr2_rate", near(nt[7], nt[5] / 5), 1);
    check("tr_live", nt[7] > 5, 1);
    $display("test transcoders done");
    @(posedge core_clk_i);
    power_state_low_i <= 1'b1;
    wait_cy(4);
    check("pll_en_low", link_pll_enable_ctl_o, 0);
    check("gates_low", port_clock_gate_o, 0);
    @(posedge core_clk_i);
    power_state_low_i <= 1'b0;
    wait_cy(14);
    check("pll_en_back", link_pll_enable_ctl_o, 4'h5);
    check("gates_back", port_clock_gate_o, 4'b1001);
    $display("test power state done");
    wr(`DPCR_OFS_PLL_CTL, 32'h15);
    wait_cy(3);
    check("genlock_sel", genlock_ref_sel_o, 1);
    check("genlock_pll", genlock_filter_pll_en_o, 1);
    rd(`DPCR_OFS_PLL_CTL, 32'h0001_5515);
    wr(`DPCR_OFS_PLL_CTL, 32'h5);
    wait_cy(3);
    check("genlock_off", genlock_filter_pll_en_o, 0);
    $display("test genlock done");
    report_and_stop();
  end
endmodule
